// ### hdl/eicm_channel.sv
// Purpose: Edge interval measurement, edge timeout, edge counting and corrected clock multiplier.
// Assumes: edge_input_pin_i is asynchronous; all other inputs are synchronous to mclk_i.
// Notes:   Rising edges of the synchronised input are counted; status flags need read-then-write-0.
`timescale 1ns/10ps

// Functional notes
// - Start bit runs the whole channel together
// - Edge captures interval, counter restarts at one
// - Interval reaching timeout compare signals match
// - Synchronise edge input, use internal pulse
// - Noise cancel blanks edges until compare
// - Count edges; match triggers channel zero
// - Capture divided by factor loads reload pair
// - Down-counter at one reloads, emits pulse
// - Multiplied pulse counter match, timing selectable
// - Edge loads scaled edge number, increments it
// - Expected counter counts pulses, reloads on edge
// - Halt select stops expected at equality
// - Corrected counter chases expected, pulse each step
// - Corrected clock goes to channels one-five
// - Clear value resets correction and channels 1-2
// - Capture sets summary and capture flags
// - Match flag set on matched count update, or at the next edge with timing select
// - Counter wrap sets overflow flag
// - 32-bit registers buffered across half accesses
// - Flag clears on write 0 after read
module eicm_channel
	import eicm_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	input  wire logic        edge_input_pin_i,
	output logic             ch0_trigger_o,
	output logic             corrected_multiplied_clock_o,
	output logic             ch12_clear_o,
	output logic [4:0]       irq_o
);

	// Register and counter state.
	eicm_ctrl_type     ctrl, next_ctrl;
	eicm_interval_type ivl, next_ivl;
	logic [4:0]  irq_enable, next_irq_enable;
	logic [5:0]  flags, next_flags;
	logic [5:0]  seen_one, next_seen_one;
	logic [15:0] rd_buf, next_rd_buf;
	logic [15:0] wr_buf, next_wr_buf;
	logic [31:0] rdata, next_rdata;
	logic        ack, next_ack;
	logic [2:0]  sync, next_sync;
	logic        blank_on, next_blank_on;
	logic [7:0]  noise_blank_counter, next_noise_blank_counter;
	logic [7:0]  noise_blank_compare, next_noise_blank_compare;
	logic [7:0]  edge_event_counter, next_edge_event_counter;
	logic [7:0]  edge_event_compare, next_edge_event_compare;
	logic [15:0] reload_buffer, next_reload_buffer;
	logic [15:0] reload_down_counter, next_reload_down_counter;
	logic [15:0] multiplied_clock_counter, next_multiplied_clock_counter;
	logic [15:0] multiplied_clock_compare, next_multiplied_clock_compare;
	logic        mclk_pending, next_mclk_pending;
	logic [15:0] edge_number_counter, next_edge_number_counter;
	logic [15:0] expected_pulse_counter, next_expected_pulse_counter;
	logic [15:0] corrected_pulse_counter, next_corrected_pulse_counter;
	logic [15:0] correction_clear_reg, next_correction_clear_reg;
	logic        trig, next_trig;
	logic        corr_pulse, next_corr_pulse;
	logic        clr_pulse, next_clr_pulse;

	// Combinational events of the current cycle.
	logic        raw_edge;
	logic        internal_edge_pulse;
	logic        raw_multiplied_clock;
	logic        tmo_match;
	logic        ev_match;
	logic        mc_match;
	logic        ivl_wrap;
	logic        corr_clear;
	logic        wr_go;
	logic        rd_go;
	logic [4:0]  shift;
	logic [31:0] divided;
	logic [5:0]  set_flags;
	logic [15:0] wd;

	// Edge pulse, divider and match decode.
	always_comb begin
		raw_edge = sync[1] & ~sync[2];
		internal_edge_pulse = raw_edge & ctrl.start & ~blank_on;
		shift = MULT_BASE_SHIFT + {3'b000, ctrl.mult_sel};
		divided = ivl.interval_counter >> shift;
		raw_multiplied_clock = ctrl.start & (reload_down_counter == RELOAD_POINT);
		tmo_match = ctrl.start & ~internal_edge_pulse
			& (ivl.interval_counter == ivl.edge_timeout_compare);
		ev_match = internal_edge_pulse
			& ((edge_event_counter + 8'h01) == edge_event_compare);
		mc_match = raw_multiplied_clock
			& (multiplied_clock_counter == multiplied_clock_compare);
		ivl_wrap = ctrl.start & ~internal_edge_pulse & (&ivl.interval_counter);
		corr_clear = ctrl.start & (corrected_pulse_counter == correction_clear_reg);
		wr_go = write_i & ack & byteenable_i[0] & byteenable_i[1];
		rd_go = read_i & ~ack;
		wd = writedata_i[15:0];
	end

	// Sticky events raised this cycle.
	always_comb begin
		set_flags = 6'h00;
		set_flags[FLG_CAP] = internal_edge_pulse;
		set_flags[FLG_TMO] = tmo_match;
		set_flags[FLG_EVT] = ev_match;
		set_flags[FLG_MCLK] = ctrl.irq_timing_sel ? (mclk_pending & internal_edge_pulse)
			: mc_match;
		set_flags[FLG_OVF] = ivl_wrap | (raw_multiplied_clock & (&multiplied_clock_counter));
		set_flags[FLG_SUM] = |set_flags[NUM_SRC-1:0];
	end

	// Next state of counters, registers and bus answer.
	always_comb begin
		next_ctrl = ctrl;
		next_ivl = ivl;
		next_irq_enable = irq_enable;
		next_flags = flags | set_flags;
		next_seen_one = seen_one;
		next_rd_buf = rd_buf;
		next_wr_buf = wr_buf;
		next_rdata = rdata;
		next_ack = (read_i | write_i) & ~ack;
		next_sync = {sync[1:0], edge_input_pin_i};
		next_blank_on = blank_on;
		next_noise_blank_counter = noise_blank_counter;
		next_noise_blank_compare = noise_blank_compare;
		next_edge_event_counter = edge_event_counter;
		next_edge_event_compare = edge_event_compare;
		next_reload_buffer = reload_buffer;
		next_reload_down_counter = reload_down_counter;
		next_multiplied_clock_counter = multiplied_clock_counter;
		next_multiplied_clock_compare = multiplied_clock_compare;
		next_mclk_pending = mclk_pending;
		next_edge_number_counter = edge_number_counter;
		next_expected_pulse_counter = expected_pulse_counter;
		next_corrected_pulse_counter = corrected_pulse_counter;
		next_correction_clear_reg = correction_clear_reg;
		next_trig = ev_match;
		next_corr_pulse = 1'b0;
		next_clr_pulse = 1'b0;
		// Noise blanking window after each accepted edge.
		if (internal_edge_pulse && ctrl.noise_en) begin
			next_blank_on = 1'b1;
			next_noise_blank_counter = 8'h00;
		end else if (blank_on && noise_blank_counter == noise_blank_compare) begin
			next_blank_on = 1'b0;
		end else if (blank_on) begin
			next_noise_blank_counter = noise_blank_counter + 8'h01;
		end
		// Interval measurement, capture and reload loading.
		if (internal_edge_pulse) begin
			next_ivl.edge_capture_reg = ivl.interval_counter;
			next_ivl.interval_counter = INTERVAL_RESTART;
			next_reload_buffer = (|divided[31:16]) ? CMP16_RESET
				: ((divided[15:0] == 16'h0000) ? RELOAD_POINT : divided[15:0]);
			next_reload_down_counter = next_reload_buffer;
			next_edge_event_counter = ev_match ? 8'h00
				: edge_event_counter + 8'h01;
		end else if (ctrl.start) begin
			next_ivl.interval_counter = ivl.interval_counter + 32'h0000_0001;
			if (raw_multiplied_clock) begin
				next_reload_down_counter = reload_buffer;
			end else if (reload_down_counter != 16'h0000) begin
				next_reload_down_counter = reload_down_counter - 16'h0001;
			end
		end
		// Multiplied clock counter and its delayed match.
		if (raw_multiplied_clock) begin
			next_multiplied_clock_counter = multiplied_clock_counter + 16'h0001;
		end
		if (mc_match) begin
			next_mclk_pending = 1'b1;
		end else if (internal_edge_pulse) begin
			next_mclk_pending = 1'b0;
		end
		// Pulse correction counters; the clear value wins over counting.
		if (corr_clear) begin
			next_edge_number_counter = 16'h0000;
			next_expected_pulse_counter = 16'h0000;
			next_corrected_pulse_counter = 16'h0000;
			next_clr_pulse = 1'b1;
		end else begin
			if (internal_edge_pulse) begin
				next_expected_pulse_counter = edge_number_counter << shift;
				next_edge_number_counter = edge_number_counter + 16'h0001;
			end else if (raw_multiplied_clock
				&& !(ctrl.halt_sel && expected_pulse_counter == edge_number_counter)) begin
				next_expected_pulse_counter = expected_pulse_counter + 16'h0001;
			end
			if (ctrl.start && corrected_pulse_counter < expected_pulse_counter) begin
				next_corrected_pulse_counter = corrected_pulse_counter + 16'h0001;
				next_corr_pulse = 1'b1;
			end
		end
		// Bus read: high half latches the low half for the second access.
		if (rd_go) begin
			next_rdata = 32'h0000_0000;
			unique case (address_i)
				ADDR_CTRL: next_rdata[5:0] = ctrl;
				ADDR_IER: next_rdata[4:0] = irq_enable;
				ADDR_STATUS: begin
					next_rdata[5:0] = flags;
					next_seen_one = seen_one | flags;
				end
				ADDR_CNT_H: begin
					next_rdata[15:0] = ivl.interval_counter[31:16];
					next_rd_buf = ivl.interval_counter[15:0];
				end
				ADDR_CAP_H: begin
					next_rdata[15:0] = ivl.edge_capture_reg[31:16];
					next_rd_buf = ivl.edge_capture_reg[15:0];
				end
				ADDR_TMO_H: begin
					next_rdata[15:0] = ivl.edge_timeout_compare[31:16];
					next_rd_buf = ivl.edge_timeout_compare[15:0];
				end
				ADDR_CNT_L, ADDR_CAP_L, ADDR_TMO_L: next_rdata[15:0] = rd_buf;
				ADDR_NB_CMP: next_rdata[7:0] = noise_blank_compare;
				ADDR_EV_CNT: next_rdata[7:0] = edge_event_counter;
				ADDR_EV_CMP: next_rdata[7:0] = edge_event_compare;
				ADDR_RELOAD: next_rdata = {reload_down_counter, reload_buffer};
				ADDR_MC_CNT: next_rdata[15:0] = multiplied_clock_counter;
				ADDR_MC_CMP: next_rdata[15:0] = multiplied_clock_compare;
				ADDR_CORR_CLR: next_rdata[15:0] = correction_clear_reg;
				ADDR_CORR_CNT: next_rdata = {expected_pulse_counter, corrected_pulse_counter};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		// Bus write at the edge where waitrequest is low.
		if (wr_go) begin
			unique case (address_i)
				ADDR_CTRL: next_ctrl = writedata_i[5:0];
				ADDR_IER: next_irq_enable = writedata_i[4:0];
				ADDR_STATUS: begin
					next_flags = (flags & ~(seen_one & ~writedata_i[5:0])) | set_flags;
					next_seen_one = seen_one & writedata_i[5:0];
				end
				ADDR_CNT_H, ADDR_TMO_H: next_wr_buf = wd;
				ADDR_CNT_L: next_ivl.interval_counter = {wr_buf, wd};
				ADDR_TMO_L: next_ivl.edge_timeout_compare = {wr_buf, wd};
				ADDR_NB_CMP: next_noise_blank_compare = writedata_i[7:0];
				ADDR_EV_CMP: next_edge_event_compare = writedata_i[7:0];
				ADDR_MC_CMP: next_multiplied_clock_compare = wd;
				ADDR_CORR_CLR: next_correction_clear_reg = wd;
				default: next_ctrl = ctrl;
			endcase
		end
	end
	// State registers.
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl <= '0;
			ivl <= {32'h0000_0000, 32'h0000_0000, TMO_RESET};
			irq_enable <= '0;
			flags <= '0;
			seen_one <= '0;
			rd_buf <= '0;
			wr_buf <= '0;
			rdata <= '0;
			ack <= 1'b0;
			sync <= '0;
			blank_on <= 1'b0;
			noise_blank_counter <= '0;
			noise_blank_compare <= CMP8_RESET;
			edge_event_counter <= '0;
			edge_event_compare <= CMP8_RESET;
			reload_buffer <= '0;
			reload_down_counter <= '0;
			multiplied_clock_counter <= '0;
			multiplied_clock_compare <= CMP16_RESET;
			mclk_pending <= 1'b0;
			edge_number_counter <= '0;
			expected_pulse_counter <= '0;
			corrected_pulse_counter <= '0;
			correction_clear_reg <= CMP16_RESET;
			trig <= 1'b0;
			corr_pulse <= 1'b0;
			clr_pulse <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ivl <= next_ivl;
			irq_enable <= next_irq_enable;
			flags <= next_flags;
			seen_one <= next_seen_one;
			rd_buf <= next_rd_buf;
			wr_buf <= next_wr_buf;
			rdata <= next_rdata;
			ack <= next_ack;
			sync <= next_sync;
			blank_on <= next_blank_on;
			noise_blank_counter <= next_noise_blank_counter;
			noise_blank_compare <= next_noise_blank_compare;
			edge_event_counter <= next_edge_event_counter;
			edge_event_compare <= next_edge_event_compare;
			reload_buffer <= next_reload_buffer;
			reload_down_counter <= next_reload_down_counter;
			multiplied_clock_counter <= next_multiplied_clock_counter;
			multiplied_clock_compare <= next_multiplied_clock_compare;
			mclk_pending <= next_mclk_pending;
			edge_number_counter <= next_edge_number_counter;
			expected_pulse_counter <= next_expected_pulse_counter;
			corrected_pulse_counter <= next_corrected_pulse_counter;
			correction_clear_reg <= next_correction_clear_reg;
			trig <= next_trig;
			corr_pulse <= next_corr_pulse;
			clr_pulse <= next_clr_pulse;
		end
	end
	// Outputs.
	assign readdata_o = rdata;
	assign waitrequest_o = (read_i | write_i) & ~ack;
	assign ch0_trigger_o = trig;
	assign corrected_multiplied_clock_o = corr_pulse;
	assign ch12_clear_o = clr_pulse;
	assign irq_o = flags[NUM_SRC-1:0] & irq_enable;
	// Checks on the channel behaviour.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	a_capture_restart: assert property (internal_edge_pulse |=>
		ivl.interval_counter == INTERVAL_RESTART
		&& ivl.edge_capture_reg == $past(ivl.interval_counter))
		else $error("Capture or restart of interval counter wrong.");
	a_capture_flags: assert property (internal_edge_pulse |=>
		flags[FLG_CAP] && flags[FLG_SUM])
		else $error("Capture did not set capture and summary flags.");
	a_stopped_idle: assert property (!ctrl.start |->
		!internal_edge_pulse && !raw_multiplied_clock)
		else $error("Channel active while stopped.");
	a_blank_window: assert property (blank_on |-> !internal_edge_pulse)
		else $error("Edge accepted inside noise window.");
	a_timeout_flag: assert property (tmo_match |=> flags[FLG_TMO])
		else $error("Timeout match did not set flag.");
	a_event_trigger: assert property (ev_match |=>
		ch0_trigger_o && edge_event_counter == 8'h00)
		else $error("Event match trigger wrong.");
	a_reload_point: assert property (raw_multiplied_clock && !internal_edge_pulse |=>
		reload_down_counter == $past(reload_buffer))
		else $error("Down counter did not reload.");
	a_corr_chase: assert property ((corrected_pulse_counter < expected_pulse_counter)
		&& ctrl.start && !corr_clear |=> corr_pulse
		&& corrected_pulse_counter == $past(corrected_pulse_counter) + 16'h0001)
		else $error("Corrected counter did not advance.");
	a_corr_clear: assert property (corr_clear |=>
		ch12_clear_o && edge_number_counter == 16'h0000 && corrected_pulse_counter == 16'h0000)
		else $error("Correction clear failed.");
	a_edge_scale: assert property (internal_edge_pulse && !corr_clear |=>
		edge_number_counter == $past(edge_number_counter) + 16'h0001)
		else $error("Edge number not incremented.");
	a_bus_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("Bus answer not in one wait cycle.");
	a_irq_gate: assert property (irq_o == (flags[4:0] & irq_enable))
		else $error("Interrupt request not flag and enable.");
	a_flag_hold: assert property ($fell(flags[FLG_CAP]) |->
		$past(wr_go) && $past(address_i) == ADDR_STATUS)
		else $error("Capture flag cleared without a status write.");
endmodule : eicm_channel

// ### hdl/eicm_pkg.sv
// Purpose: Shared constants and types for the edge interval clock multiplier channel.
// Assumes: 32-bit Avalon-MM register bus with byte addresses, one word per register.
// Notes:   32-bit registers are split into high and low half words.
package eicm_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_IER      = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_CNT_H    = 8'h0c;
	localparam logic [7:0] ADDR_CNT_L    = 8'h10;
	localparam logic [7:0] ADDR_CAP_H    = 8'h14;
	localparam logic [7:0] ADDR_CAP_L    = 8'h18;
	localparam logic [7:0] ADDR_TMO_H    = 8'h1c;
	localparam logic [7:0] ADDR_TMO_L    = 8'h20;
	localparam logic [7:0] ADDR_NB_CMP   = 8'h24;
	localparam logic [7:0] ADDR_EV_CNT   = 8'h28;
	localparam logic [7:0] ADDR_EV_CMP   = 8'h2c;
	localparam logic [7:0] ADDR_RELOAD   = 8'h30;
	localparam logic [7:0] ADDR_MC_CNT   = 8'h34;
	localparam logic [7:0] ADDR_MC_CMP   = 8'h38;
	localparam logic [7:0] ADDR_CORR_CLR = 8'h3c;
	localparam logic [7:0] ADDR_CORR_CNT = 8'h40;

	// Status and enable bit positions.
	localparam int FLG_CAP  = 0;
	localparam int FLG_TMO  = 1;
	localparam int FLG_EVT  = 2;
	localparam int FLG_MCLK = 3;
	localparam int FLG_OVF  = 4;
	localparam int FLG_SUM  = 5;
	localparam int NUM_SRC  = 5;

	// Values after reset and fixed counts.
	localparam logic [31:0] INTERVAL_RESTART = 32'h0000_0001;
	localparam logic [31:0] TMO_RESET        = 32'hffff_ffff;
	localparam logic [7:0]  CMP8_RESET       = 8'hff;
	localparam logic [15:0] CMP16_RESET      = 16'hffff;
	localparam logic [15:0] RELOAD_POINT     = 16'h0001;
	localparam logic [4:0]  MULT_BASE_SHIFT  = 5'd5;

	// Control register layout, high bits first.
	typedef struct packed {
		logic       irq_timing_sel;
		logic       halt_sel;
		logic [1:0] mult_sel;
		logic       noise_en;
		logic       start;
	} eicm_ctrl_type;

	// Interval, capture and timeout words for one channel.
	typedef struct packed {
		logic [31:0] interval_counter;
		logic [31:0] edge_capture_reg;
		logic [31:0] edge_timeout_compare;
	} eicm_interval_type;

endpackage : eicm_pkg

// ### verification/eicm_edge_src.sv
// Purpose: Edge source model that stands on the far side of the edge input.
// Assumes: Calls are made just after a rising clock edge.
// Notes:   The line rests low between pulses; spacing is set by the caller.
`timescale 1ns/10ps
module eicm_edge_src (
	input  wire logic mclk_i,
	output logic      edge_o
);
	// Line idles low until the first pulse.
	initial begin
		edge_o = 1'b0;
	end

	// Drive one rising edge and hold the line high for two cycles.
	task automatic pulse();
		edge_o <= 1'b1;
		repeat (2) @(posedge mclk_i);
		edge_o <= 1'b0;
	endtask : pulse
endmodule : eicm_edge_src

// ### verification/edge_interval_clock_multiplier_tb.sv
// Purpose: Self-checking bench for the edge interval clock multiplier channel.
// Assumes: The register bus answers in its own time; edges come from the source model.
// Notes:   Corrected pulse counts get slack because the window ends cut pulses.
`timescale 1ns/10ps
module edge_interval_clock_multiplier_tb
	import eicm_pkg::*;
;
	logic        mclk_i      = 1'b0;
	logic        nrst_i      = 1'b0;
	logic [7:0]  address_i   = 8'h00;
	logic        read_i      = 1'b0;
	logic        write_i     = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [3:0]  byteenable_i = 4'hf;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        pin;
	logic        trig;
	logic        corr;
	logic        clr;
	logic [4:0]  irq_o;
	logic [31:0] rdata;
	int          miscompares = 0;
	int          comparisons = 0;
	int          ntrig;
	int          ncorr;

	// Free-running 100 MHz clock.
	always #5 mclk_i = ~mclk_i;

	eicm_edge_src src (.mclk_i(mclk_i), .edge_o(pin));

	eicm_channel dut (
		.mclk_i                       (mclk_i),
		.nrst_i                       (nrst_i),
		.address_i                    (address_i),
		.read_i                       (read_i),
		.write_i                      (write_i),
		.writedata_i                  (writedata_i),
		.byteenable_i                 (byteenable_i),
		.readdata_o                   (readdata_o),
		.waitrequest_o                (waitrequest_o),
		.edge_input_pin_i             (pin),
		.ch0_trigger_o                (trig),
		.corrected_multiplied_clock_o (corr),
		.ch12_clear_o                 (clr),
		.irq_o                        (irq_o)
	);

	// Print the counts and the verdict, then stop.
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One bus cycle; the request holds until waitrequest is sampled low at a rising edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address_i   <= a;
		writedata_i <= d;
		write_i     <= wr;
		read_i      <= !wr;
		@(posedge mclk_i);
		while (waitrequest_o !== 1'b0 && n < 20) begin
			@(posedge mclk_i);
			n++;
		end
		rdata = readdata_o;
		write_i <= 1'b0;
		read_i  <= 1'b0;
		if (n == 20) begin
			miscompares++;
			$display("mismatch at %0t: no bus answer", $time);
			conclude();
		end
		@(posedge mclk_i);
	endtask : bus

	task automatic rd32(input logic [7:0] a);
		logic [15:0] hi;
		bus(1'b0, a, 32'h0);
		hi = rdata[15:0];
		bus(1'b0, 8'(a + 8'h04), 32'h0);
		rdata = {hi, rdata[15:0]};
	endtask : rd32

	// Send edges at a fixed spacing, counting outputs in each gap.
	task automatic edges(input int cnt, input int gap);
		ntrig = 0;
		for (int i = 0; i < cnt; i++) begin
			src.pulse();
			ncorr = 0;
			repeat (gap - 2) begin
				@(negedge mclk_i);
				ntrig += int'(trig === 1'b1);
				ncorr += int'(corr === 1'b1);
				@(posedge mclk_i);
			end
		end
	endtask : edges

	task automatic test_reset();
		bus(1'b0, ADDR_CTRL, 32'h0);
		check(rdata, 32'h0);
		rd32(ADDR_TMO_H);
		check(rdata, 32'hffff_ffff);
		bus(1'b0, ADDR_MC_CMP, 32'h0);
		check(rdata, 32'h0000_ffff);
		bus(1'b0, 8'h44, 32'h0);
		check(rdata, 32'h0);
		$display("test reset done");
	endtask : test_reset

	task automatic test_capture();
		bus(1'b1, ADDR_EV_CMP, 32'h2);
		bus(1'b1, ADDR_IER, 32'h1f);
		// Preload the interval so that the first capture is one cycle short of a full gap.
		bus(1'b1, ADDR_CNT_H, 32'h0);
		bus(1'b1, ADDR_CNT_L, 32'd316);
		bus(1'b1, ADDR_CTRL, 32'h1);
		edges(4, 320);
		check(32'(ntrig), 32'h2);
		check(32'(ncorr >= 30 && ncorr <= 33), 32'h1);
		rd32(ADDR_CAP_H);
		check(rdata, 32'd320);
		bus(1'b0, ADDR_RELOAD, 32'h0);
		check(32'(rdata[15:0]), 32'h000a);
		check(32'(irq_o[0]), 32'h1);
		$display("test capture done");
	endtask : test_capture

	task automatic test_clear();
		bus(1'b1, ADDR_STATUS, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rdata & 32'h25, 32'h25);
		bus(1'b1, ADDR_STATUS, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rdata & 32'h25, 32'h0);
		check(32'(irq_o), 32'h0);
		$display("test clear done");
	endtask : test_clear

	task automatic test_noise();
		bus(1'b0, ADDR_EV_CNT, 32'h0);
		check(rdata, 32'h0);
		bus(1'b1, ADDR_NB_CMP, 32'h14);
		bus(1'b1, ADDR_CTRL, 32'h3);
		src.pulse();
		repeat (4) @(posedge mclk_i);
		src.pulse();
		repeat (40) @(posedge mclk_i);
		bus(1'b0, ADDR_EV_CNT, 32'h0);
		check(rdata, 32'h1);
		$display("test noise done");
	endtask : test_noise

	task automatic test_timeout();
		src.pulse();
		bus(1'b1, ADDR_TMO_H, 32'h0);
		bus(1'b1, ADDR_TMO_L, 32'h40);
		repeat (30) @(posedge mclk_i);
		@(negedge mclk_i);
		check(32'(irq_o[1]), 32'h0);
		repeat (40) @(posedge mclk_i);
		@(negedge mclk_i);
		check(32'(irq_o[1]), 32'h1);
		@(posedge mclk_i);
		rd32(ADDR_TMO_H);
		check(rdata, 32'h40);
		$display("test timeout done");
	endtask : test_timeout

	// Times 64 with the multiplied clock flag held back to the next edge.
	task automatic test_mult();
		logic [31:0] cap;
		logic [15:0] v;
		bus(1'b1, ADDR_CTRL, 32'h25);
		bus(1'b0, ADDR_MC_CNT, 32'h0);
		v = rdata[15:0];
		bus(1'b1, ADDR_MC_CMP, 32'(v + 16'd40));
		repeat (60) @(posedge mclk_i);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rdata & 32'h08, 32'h0);
		src.pulse();
		repeat (6) @(posedge mclk_i);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rdata & 32'h08, 32'h08);
		check(32'(irq_o[3]), 32'h1);
		rd32(ADDR_CAP_H);
		cap = rdata;
		bus(1'b0, ADDR_RELOAD, 32'h0);
		check(32'(rdata[15:0]), cap >> 6);
		$display("test mult done");
	endtask : test_mult

	// Freeze the channel, aim the clear value at the corrected count, restart with halt.
	task automatic test_corr_clear();
		logic [15:0] c;
		int          nclr;
		bus(1'b1, ADDR_CTRL, 32'h0);
		bus(1'b0, ADDR_CORR_CNT, 32'h0);
		c = rdata[15:0];
		bus(1'b1, ADDR_CORR_CLR, 32'(c));
		bus(1'b1, ADDR_CTRL, 32'h11);
		nclr = 0;
		repeat (8) begin
			@(negedge mclk_i);
			nclr += int'(clr === 1'b1);
			@(posedge mclk_i);
		end
		check(32'(nclr), 32'h1);
		bus(1'b0, ADDR_CORR_CNT, 32'h0);
		check(rdata, 32'h0);
		$display("test corr clear done");
	endtask : test_corr_clear

	// Main sequence: reset for ten cycles, then each scenario in turn.
	initial begin
		repeat (10) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		test_reset();
		test_capture();
		test_clear();
		test_noise();
		test_timeout();
		test_mult();
		test_corr_clear();
		conclude();
	end
endmodule : edge_interval_clock_multiplier_tb
